//--- memory_select_pkg.sv
// Summary of operation
// - Four memories A to D; memory A is always valid and the fallback.
// - Switch type setting picks momentary push button or static latching switch.
// - Last-memory flag dedicates the secondary input to jumping to memory D.
// - Four modes from switch type and flag; mode 4 uses at most three memories.
// - Primary and secondary select polarity: pull-down means closed reads high, pull-up closed reads low.
// - Single momentary mode starts in memory A after reset.
// - Each press loads next valid memory alphabetically, skipping invalid ones.
// - Press in the last valid memory wraps around to memory A.
// - With auto telecoil, closing the secondary input moves to memory D.
// - After debounced opening, return to the memory active before D.
// - Closed-to-open starts debounce; leave D only after a full open period.
// - Exactly one of analog or digital volume control is active.
// - Volume comes from a static software value or the external control.
// - Digital mode: up button raises gain, down button lowers gain.
// - Digital buttons act as momentary or rocker; rocker may select memories.
// - Analog volume uses logarithmic or linear taper by setting.
// - Four trimmers feed nineteen parameters of sixteen values; sharing is allowed.
// - Trimmer position change updates parameter values promptly.
// - Momentary-plus-static: closed secondary forces D, primary ignored, reopen restores.
// - Dual static mode: primary and secondary form a binary memory index.
// - Static modes fall back to memory A for an invalid selection; in mode 4 a closed secondary still selects D even when D is invalid.
package memory_select_pkg;
  localparam int NUM_MEMORIES = 4;
  localparam int NUM_TRIMMERS = 4;
  localparam int NUM_PARAMS = 19;
  localparam int TRIM_BITS = 4;
  localparam int VOL_BITS = 8;
  localparam int DEBOUNCE_BITS = 10;
  localparam logic [1:0] MEM_A = 2'h0;
  localparam logic [1:0] MEM_B = 2'h1;
  localparam logic [1:0] MEM_C = 2'h2;
  localparam logic [1:0] MEM_D = 2'h3;
  // highest usable memory index with and without the last-memory flag
  localparam logic [1:0] LIMIT_ALL = 2'h3;
  localparam logic [1:0] LIMIT_JUMP = 2'h2;
  localparam logic [7:0] VOL_RESET = 8'h80;
  localparam logic [7:0] VOL_STEP = 8'h04;
  localparam logic [7:0] VOL_MAX = 8'hff;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLOCK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h1,
    ST_JUMPED = 3'h2,
    ST_SETTLE = 3'h4
  } jump_state_t;
endpackage

//--- switch_conditioner.sv
`timescale 1ns/100ps
module switch_conditioner #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] raw_in,
  input wire logic [WIDTH-1:0] pullup_in,
  output logic [WIDTH-1:0] closed_out,
  output logic [WIDTH-1:0] press_out,
  output logic [WIDTH-1:0] release_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] closed_prev;
  logic [1:0] warm;

  // synchronizers clear to zero, which reads as closed for a pull-up input;
  // report every input open until the second stage holds a real pin sample
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      warm <= 2'h0;
    end else if (!warm[1]) begin
      warm <= warm + 2'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta[i] <= 1'b0;
          sync[i] <= 1'b0;
          closed_prev[i] <= 1'b0;
        end else begin
          meta[i] <= raw_in[i];
          sync[i] <= meta[i];
          closed_prev[i] <= closed_out[i];
        end
      end
      assign closed_out[i] = warm[1] & (sync[i] ^ pullup_in[i]);
      assign press_out[i] = closed_out[i] & ~closed_prev[i];
      assign release_out[i] = ~closed_out[i] & closed_prev[i];
    end
  endgenerate
endmodule

//--- memory_select_switch_control.sv
`timescale 1ns/100ps
module memory_select_switch_control #(
  parameter int TICK_CYCLES = memory_select_pkg::TICK_CYCLES
) (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic SELECT_INPUT_PRIMARY_IN,
  input wire logic SELECT_INPUT_SECONDARY_IN,
  input wire logic SWITCH_TYPE_SETTING_IN,
  input wire logic LAST_MEMORY_FLAG_IN,
  input wire logic PRIMARY_POLARITY_SETTING_IN,
  input wire logic SECONDARY_POLARITY_SETTING_IN,
  input wire logic [3:0] MEMORY_VALID_IN,
  input wire logic [9:0] DEBOUNCE_PERIOD_IN,
  input wire logic VOLUME_UP_INPUT_IN,
  input wire logic VOLUME_DOWN_INPUT_IN,
  input wire logic VOLUME_DIGITAL_IN,
  input wire logic VOLUME_EXTERNAL_IN,
  input wire logic [7:0] STATIC_VOLUME_IN,
  input wire logic [7:0] ANALOG_VOLUME_IN,
  input wire logic TAPER_LOG_IN,
  input wire logic ROCKER_MEMORY_IN,
  input wire logic [15:0] TRIMMER_POS_IN,
  input wire logic [37:0] TRIMMER_MAP_IN,
  output logic [1:0] MEMORY_SELECT_OUT,
  output logic MEMORY_LOAD_OUT,
  output logic [7:0] VOLUME_OUT,
  output logic VOLUME_ANALOG_ACTIVE_OUT,
  output logic VOLUME_DIGITAL_ACTIVE_OUT,
  output logic [75:0] PARAM_VALUE_OUT,
  output logic PARAM_UPDATE_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // input conditioning
  logic [3:0] closed;
  logic [3:0] press;
  logic [3:0] release_evt;

  switch_conditioner #(.WIDTH(4)) u_cond (
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .raw_in({VOLUME_DOWN_INPUT_IN, VOLUME_UP_INPUT_IN,
             SELECT_INPUT_SECONDARY_IN, SELECT_INPUT_PRIMARY_IN}),
    .pullup_in({2'h0, SECONDARY_POLARITY_SETTING_IN,
                PRIMARY_POLARITY_SETTING_IN}),
    .closed_out(closed),
    .press_out(press),
    .release_out(release_evt)
  );

  logic pri_closed;
  logic sec_closed;
  logic pri_press;
  logic sec_release;
  logic up_press;
  logic down_press;
  assign pri_closed = closed[0];
  assign sec_closed = closed[1];
  assign pri_press = press[0];
  assign sec_release = release_evt[1];
  assign up_press = press[2];
  assign down_press = press[3];

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and memory stepping
  logic momentary;
  logic jump_mode;
  logic rocker_mem;
  logic [3:0] valid;
  logic [1:0] limit;
  assign momentary = ~SWITCH_TYPE_SETTING_IN;
  assign jump_mode = LAST_MEMORY_FLAG_IN;
  // rocker memory stepping only with digital buttons and momentary select
  assign rocker_mem = ROCKER_MEMORY_IN & VOLUME_DIGITAL_IN & momentary;
  assign valid = {MEMORY_VALID_IN[3:1], 1'b1};
  // with the flag set, memory D is reserved for the jump
  assign limit = jump_mode ? memory_select_pkg::LIMIT_JUMP
                           : memory_select_pkg::LIMIT_ALL;

  function automatic logic [1:0] step_mem(input logic [1:0] cur,
                                          input logic up,
                                          input logic [3:0] v,
                                          input logic [1:0] lim);
    logic [1:0] r;
    logic [1:0] c;
    logic found;
    r = memory_select_pkg::MEM_A;
    c = cur;
    found = 1'b0;
    for (int i = 1; i < 4; i++) begin
      c = up ? cur + 2'(i) : cur - 2'(i);
      if (!found && c <= lim && v[c]) begin
        r = c;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  logic [1:0] active;
  logic [1:0] saved;
  logic [1:0] up_target;
  logic [1:0] down_target;
  logic [1:0] static_sel;
  logic [1:0] static_res;
  assign up_target = step_mem(active, 1'b1, valid, limit);
  assign down_target = step_mem(active, 1'b0, valid, limit);
  always_comb begin
    if (jump_mode) begin
      if (sec_closed) begin
        static_sel = memory_select_pkg::MEM_D;
      end else begin
        static_sel = pri_closed ? memory_select_pkg::MEM_B
                                : memory_select_pkg::MEM_A;
      end
    end else begin
      static_sel = {sec_closed, pri_closed};
    end
  end
  assign static_res = valid[static_sel] ? static_sel
                                        : memory_select_pkg::MEM_A;

  ////////////////////////////////////////////////////////////////////////////
  // auto telecoil jump and debounce
  memory_select_pkg::jump_state_t state;
  memory_select_pkg::jump_state_t next_state;
  logic [16:0] tick_count;
  logic tick;
  logic [9:0] settle_count;
  logic settle_done;

  // slow sampling rate for the debounce period
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tick_count <= 17'h0;
    end else if (tick) begin
      tick_count <= 17'h0;
    end else begin
      tick_count <= tick_count + 17'h1;
    end
  end
  assign tick = (tick_count == 17'(TICK_CYCLES - 1));

  assign settle_done = (settle_count >= DEBOUNCE_PERIOD_IN);
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      settle_count <= 10'h0;
    end else if (state != memory_select_pkg::ST_SETTLE || sec_closed) begin
      settle_count <= 10'h0;
    end else if (tick && !settle_done) begin
      settle_count <= settle_count + 10'h1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      memory_select_pkg::ST_NORMAL: begin
        if (jump_mode && sec_closed) begin
          next_state = memory_select_pkg::ST_JUMPED;
        end
      end
      memory_select_pkg::ST_JUMPED: begin
        if (!jump_mode) begin
          next_state = memory_select_pkg::ST_NORMAL;
        end else if (sec_release) begin
          next_state = memory_select_pkg::ST_SETTLE;
        end
      end
      memory_select_pkg::ST_SETTLE: begin
        if (!jump_mode) begin
          next_state = memory_select_pkg::ST_NORMAL;
        end else if (sec_closed) begin
          next_state = memory_select_pkg::ST_JUMPED;
        end else if (settle_done) begin
          next_state = memory_select_pkg::ST_NORMAL;
        end
      end
      default: next_state = memory_select_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= memory_select_pkg::ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // active memory
  logic [1:0] next_active;
  always_comb begin
    next_active = active;
    case (state)
      memory_select_pkg::ST_NORMAL: begin
        if (jump_mode && sec_closed) begin
          next_active = memory_select_pkg::MEM_D;
        end else if (!momentary) begin
          next_active = static_res;
        end else if (rocker_mem && up_press && !down_press) begin
          next_active = up_target;
        end else if (rocker_mem && down_press && !up_press) begin
          next_active = down_target;
        end else if (pri_press) begin
          next_active = up_target;
        end
      end
      memory_select_pkg::ST_JUMPED: begin
        next_active = memory_select_pkg::MEM_D;
      end
      memory_select_pkg::ST_SETTLE: begin
        if (next_state == memory_select_pkg::ST_NORMAL) begin
          next_active = saved;
        end else begin
          next_active = memory_select_pkg::MEM_D;
        end
      end
      default: next_active = memory_select_pkg::MEM_A;
    endcase
  end

  // startup lands in A; static modes then follow the switches
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      active <= memory_select_pkg::MEM_A;
      MEMORY_LOAD_OUT <= 1'b0;
    end else begin
      active <= next_active;
      MEMORY_LOAD_OUT <= (next_active != active);
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      saved <= memory_select_pkg::MEM_A;
    end else if (state == memory_select_pkg::ST_NORMAL &&
                 next_state == memory_select_pkg::ST_JUMPED) begin
      saved <= active;
    end
  end
  assign MEMORY_SELECT_OUT = active;

  ////////////////////////////////////////////////////////////////////////////
  // volume
  logic [15:0] squared;
  logic [7:0] tapered;
  assign squared = ANALOG_VOLUME_IN * ANALOG_VOLUME_IN;
  // squared curve approximates an audio taper without a table
  assign tapered = TAPER_LOG_IN ? squared[15:8] : ANALOG_VOLUME_IN;
  assign VOLUME_DIGITAL_ACTIVE_OUT = VOLUME_DIGITAL_IN;
  assign VOLUME_ANALOG_ACTIVE_OUT = ~VOLUME_DIGITAL_IN;

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      VOLUME_OUT <= memory_select_pkg::VOL_RESET;
    end else if (!VOLUME_EXTERNAL_IN) begin
      VOLUME_OUT <= STATIC_VOLUME_IN;
    end else if (!VOLUME_DIGITAL_IN) begin
      VOLUME_OUT <= tapered;
    end else if (!rocker_mem && up_press && !down_press) begin
      if (VOLUME_OUT > memory_select_pkg::VOL_MAX - memory_select_pkg::VOL_STEP)
      begin
        VOLUME_OUT <= memory_select_pkg::VOL_MAX;
      end else begin
        VOLUME_OUT <= VOLUME_OUT + memory_select_pkg::VOL_STEP;
      end
    end else if (!rocker_mem && down_press && !up_press) begin
      if (VOLUME_OUT < memory_select_pkg::VOL_STEP) begin
        VOLUME_OUT <= 8'h00;
      end else begin
        VOLUME_OUT <= VOLUME_OUT - memory_select_pkg::VOL_STEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trimmer to parameter mapping
  logic [18:0] changed;
  genvar p;
  generate
    for (p = 0; p < memory_select_pkg::NUM_PARAMS; p++) begin : g_param
      logic [1:0] src;
      logic [3:0] pos;
      assign src = TRIMMER_MAP_IN[2*p +: 2];
      assign pos = TRIMMER_POS_IN[4*src +: 4];
      assign changed[p] = (pos != PARAM_VALUE_OUT[4*p +: 4]);
      always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          PARAM_VALUE_OUT[4*p +: 4] <= 4'h0;
        end else begin
          PARAM_VALUE_OUT[4*p +: 4] <= pos;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      PARAM_UPDATE_OUT <= 1'b0;
    end else begin
      PARAM_UPDATE_OUT <= |changed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic first_cycle;
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end
  logic mode1;
  assign mode1 = momentary & ~jump_mode;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  a_start_in_a: assert property (first_cycle |-> active == 2'h0)
    else $error("memory not A right after reset");
  a_press_steps: assert property (
    (mode1 && !rocker_mem && pri_press &&
     state == memory_select_pkg::ST_NORMAL) |=> active == $past(up_target))
    else $error("press did not load next valid memory");
  a_held_no_step: assert property (
    (mode1 && !rocker_mem && !pri_press &&
     state == memory_select_pkg::ST_NORMAL) |=> $stable(active))
    else $error("memory moved without a new press");
  a_jump_to_d: assert property (
    (jump_mode && sec_closed && state == memory_select_pkg::ST_NORMAL)
    |=> active == 2'h3 ##1 state == memory_select_pkg::ST_JUMPED)
    else $error("closed secondary did not select D");
  a_hold_debounce: assert property (
    (jump_mode && state == memory_select_pkg::ST_SETTLE && !settle_done)
    |=> active == 2'h3)
    else $error("left D before debounce period");
  a_restore_memory: assert property (
    (jump_mode && state == memory_select_pkg::ST_SETTLE && settle_done &&
     !sec_closed) |=> active == $past(saved))
    else $error("memory before D not restored");
  a_static_binary: assert property (
    (!momentary && !jump_mode && state == memory_select_pkg::ST_NORMAL)
    |=> active == $past(static_res))
    else $error("static selection not followed");
  a_invalid_to_a: assert property (
    (!momentary && !sec_closed && !valid[static_sel] &&
     state == memory_select_pkg::ST_NORMAL) |=> active == 2'h0)
    else $error("invalid static selection not A");
  a_one_volume: assert property (
    VOLUME_ANALOG_ACTIVE_OUT != VOLUME_DIGITAL_ACTIVE_OUT)
    else $error("volume methods both or neither");
  a_static_volume: assert property (
    !VOLUME_EXTERNAL_IN |=> VOLUME_OUT == $past(STATIC_VOLUME_IN))
    else $error("static volume not applied");
  a_volume_up: assert property (
    (VOLUME_EXTERNAL_IN && VOLUME_DIGITAL_IN && !rocker_mem && up_press &&
     !down_press && VOLUME_OUT <= 8'hfb)
    |=> VOLUME_OUT == $past(VOLUME_OUT) + 8'h04)
    else $error("volume up step wrong");

  c_wrap_to_a: cover property (
    mode1 && pri_press && active != 2'h0 ##1 active == 2'h0);
  c_jump_restore: cover property (
    state == memory_select_pkg::ST_SETTLE ##1
    state == memory_select_pkg::ST_NORMAL);
  c_volume_down: cover property (
    VOLUME_DIGITAL_IN && VOLUME_EXTERNAL_IN && down_press);
endmodule

//--- user_switch_model.sv
`timescale 1ns/100ps
module user_switch_model (
  input wire logic primary_closed_in,
  input wire logic secondary_closed_in,
  input wire logic primary_pullup_in,
  input wire logic secondary_pullup_in,
  input wire logic up_closed_in,
  input wire logic down_closed_in,
  output logic primary_pin_out,
  output logic secondary_pin_out,
  output logic up_pin_out,
  output logic down_pin_out
);
  // closed switch pulls the pin away from its resistor level
  assign primary_pin_out = primary_pullup_in ? ~primary_closed_in
                                             : primary_closed_in;
  assign secondary_pin_out = secondary_pullup_in ? ~secondary_closed_in
                                                 : secondary_closed_in;
  // volume buttons are wired to the supply, closed reads high
  assign up_pin_out = up_closed_in;
  assign down_pin_out = down_closed_in;
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic p_closed = 1'b0, s_closed = 1'b0, up_closed = 1'b0, dn_closed = 1'b0;
  logic p_pull = 1'b0, s_pull = 1'b1;
  logic p_pin, s_pin, up_pin, dn_pin;
  logic sw_type = 1'b0, flag = 1'b0, vol_dig = 1'b1, vol_ext = 1'b1;
  logic taper = 1'b0, rocker = 1'b0;
  logic [3:0] valid = 4'hf;
  logic [9:0] deb = 10'h003;
  logic [7:0] stat_vol = 8'h33, ana_vol = 8'h60;
  logic [15:0] trim_pos = 16'h0000;
  logic [37:0] trim_map = 38'h0000000001;
  logic [1:0] mem;
  logic load, ana_act, dig_act, upd;
  logic [7:0] vol;
  logic [75:0] params;
  int err_count = 0;
  int comparisons = 0;

  always #5 clock_in = ~clock_in;

  user_switch_model sw_u (
    .primary_closed_in(p_closed), .secondary_closed_in(s_closed),
    .primary_pullup_in(p_pull), .secondary_pullup_in(s_pull),
    .up_closed_in(up_closed), .down_closed_in(dn_closed),
    .primary_pin_out(p_pin), .secondary_pin_out(s_pin),
    .up_pin_out(up_pin), .down_pin_out(dn_pin));

  // short tick keeps the debounce wait to tens of cycles
  memory_select_switch_control #(.TICK_CYCLES(4)) dut_u (
    .CLOCK_IN(clock_in), .RST_IN(rst_in),
    .SELECT_INPUT_PRIMARY_IN(p_pin), .SELECT_INPUT_SECONDARY_IN(s_pin),
    .SWITCH_TYPE_SETTING_IN(sw_type), .LAST_MEMORY_FLAG_IN(flag),
    .PRIMARY_POLARITY_SETTING_IN(p_pull),
    .SECONDARY_POLARITY_SETTING_IN(s_pull),
    .MEMORY_VALID_IN(valid), .DEBOUNCE_PERIOD_IN(deb),
    .VOLUME_UP_INPUT_IN(up_pin), .VOLUME_DOWN_INPUT_IN(dn_pin),
    .VOLUME_DIGITAL_IN(vol_dig), .VOLUME_EXTERNAL_IN(vol_ext),
    .STATIC_VOLUME_IN(stat_vol), .ANALOG_VOLUME_IN(ana_vol),
    .TAPER_LOG_IN(taper), .ROCKER_MEMORY_IN(rocker),
    .TRIMMER_POS_IN(trim_pos), .TRIMMER_MAP_IN(trim_map),
    .MEMORY_SELECT_OUT(mem), .MEMORY_LOAD_OUT(load), .VOLUME_OUT(vol),
    .VOLUME_ANALOG_ACTIVE_OUT(ana_act), .VOLUME_DIGITAL_ACTIVE_OUT(dig_act),
    .PARAM_VALUE_OUT(params), .PARAM_UPDATE_OUT(upd));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait, then judge the memory reached
  task automatic wait_mem(input logic [1:0] e);
    for (int i = 0; i < 60 && mem !== e; i++) cyc(1);
    chk("memory", {6'h00, e}, {6'h00, mem});
  endtask

  // held well past the sync delay so a repeat step would show
  task automatic press(input int which);
    if (which == 0) p_closed = 1'b1;
    if (which == 1) up_closed = 1'b1;
    if (which == 2) dn_closed = 1'b1;
    if (which == 3) begin
      up_closed = 1'b1;
      dn_closed = 1'b1;
    end
    cyc(10);
    p_closed = 1'b0;
    up_closed = 1'b0;
    dn_closed = 1'b0;
    cyc(6);
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_momentary;
    logic [1:0] seq [4];
    seq = '{memory_select_pkg::MEM_B, memory_select_pkg::MEM_C,
            memory_select_pkg::MEM_D, memory_select_pkg::MEM_A};
    chk("start", 8'h00, {6'h00, mem});
    p_closed = 1'b1;
    cyc(3);
    for (int i = 0; i < 8 && load !== 1'b1; i++) cyc(1);
    chk("load pulse", 8'h01, {7'h00, load});
    chk("after first", 8'h01, {6'h00, mem});
    cyc(1);
    chk("load drop", 8'h00, {7'h00, load});
    cyc(8);
    p_closed = 1'b0;
    cyc(6);
    chk("held once", 8'h01, {6'h00, mem});
    for (int i = 1; i < 4; i++) begin
      press(0);
      chk("advance", {6'h00, seq[i]}, {6'h00, mem});
    end
    valid = 4'h4; // bit0 clear must still leave A usable
    press(0);
    chk("skip b", 8'h02, {6'h00, mem});
    press(0);
    chk("wrap", 8'h00, {6'h00, mem});
    valid = 4'h0;
    press(0);
    chk("only a", 8'h00, {6'h00, mem});
    valid = 4'hf;
  endtask

  task automatic test_volume;
    chk("digital act", 8'h01, {7'h00, dig_act});
    chk("analog act", 8'h00, {7'h00, ana_act});
    chk("vol reset", 8'h80, vol);
    press(1);
    chk("vol up", 8'h84, vol);
    press(2);
    press(2);
    chk("vol down", 8'h7c, vol);
    press(3);
    chk("vol both", 8'h7c, vol);
    rocker = 1'b1;
    press(1);
    chk("rocker up", 8'h01, {6'h00, mem});
    press(2);
    chk("rocker dn", 8'h00, {6'h00, mem});
    chk("rocker vol", 8'h7c, vol);
    rocker = 1'b0;
    vol_dig = 1'b0;
    cyc(2);
    chk("analog act2", 8'h01, {7'h00, ana_act});
    chk("digital act2", 8'h00, {7'h00, dig_act});
    chk("linear", 8'h60, vol);
    taper = 1'b1;
    cyc(2);
    chk("log", 8'h24, vol);
    vol_ext = 1'b0;
    cyc(2);
    chk("static", 8'h33, vol);
    vol_dig = 1'b1;
  endtask

  task automatic test_telecoil;
    flag = 1'b1;
    cyc(4);
    press(0);
    chk("pre jump", 8'h01, {6'h00, mem});
    s_closed = 1'b1;
    wait_mem(memory_select_pkg::MEM_D);
    press(0);
    chk("ignored", 8'h03, {6'h00, mem});
    s_closed = 1'b0;
    cyc(6);
    chk("bounce hold", 8'h03, {6'h00, mem});
    s_closed = 1'b1;
    cyc(4);
    s_closed = 1'b0;
    cyc(10);
    chk("restart", 8'h03, {6'h00, mem});
    wait_mem(memory_select_pkg::MEM_B);
    press(0);
    press(0);
    chk("no d", 8'h00, {6'h00, mem});
  endtask

  task automatic test_static;
    logic [1:0] exp3 [4];
    exp3 = '{2'h0, 2'h1, 2'h2, 2'h3};
    sw_type = 1'b1;
    flag = 1'b0;
    for (int i = 0; i < 4; i++) begin
      p_closed = i[0];
      s_closed = i[1];
      wait_mem(exp3[i]);
      cyc(8);
      chk("static hold", {6'h00, exp3[i]}, {6'h00, mem});
    end
    valid = 4'h3;
    p_closed = 1'b0;
    cyc(10);
    chk("invalid c", 8'h00, {6'h00, mem});
    valid = 4'hf;
    flag = 1'b1;
    s_closed = 1'b0;
    p_closed = 1'b1;
    wait_mem(memory_select_pkg::MEM_B);
    s_closed = 1'b1;
    wait_mem(memory_select_pkg::MEM_D);
    s_closed = 1'b0;
    cyc(60);
    chk("mode4 back", 8'h01, {6'h00, mem});
    p_closed = 1'b0;
    wait_mem(memory_select_pkg::MEM_A);
  endtask

  task automatic test_trimmer;
    trim_pos = 16'h00a0;
    cyc(1);
    chk("param0", 8'h0a, {4'h0, params[3:0]});
    chk("param1", 8'h00, {4'h0, params[7:4]});
    chk("update", 8'h01, {7'h00, upd});
    trim_map = 38'h3fffffffff;
    trim_pos = 16'hf0a0;
    cyc(1);
    chk("shared", 8'hff, {params[75:72], params[7:4]});
    cyc(2);
    chk("update drop", 8'h00, {7'h00, upd});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    chk("reset mem", 8'h00, {6'h00, mem});
    chk("reset vol", 8'h80, vol);
    chk("reset param", 8'h00, params[7:0]);
    rst_in = 1'b0;
    cyc(6);
    test_momentary();
    test_volume();
    test_telecoil();
    test_static();
    test_trimmer();
    tally_and_finish();
  end

  // the sequence needs well under two thousand cycles
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule
